// file: inc/cspr_pkg.sv
// Constants for the CPU stack pointer and RAM stack block.
// Assumes an 8-bit data path and one flat address map.
package cspr_pkg;
	// Address map
	localparam int ADDR_W = 13;
	localparam logic [12:0] RAM_LIMIT = 13'h0080;
	localparam logic [12:0] STACK_TOP = 13'h007f;
	localparam logic [12:0] STACK_BASE = 13'h0060;
	localparam logic [12:0] PERIPH_LIMIT = 13'h0010;
	localparam logic [12:0] VEC_BASE = 13'h1ff6;
	localparam logic [12:0] VEC_RESET = 13'h1ffe;
	// Stack frame sizes in bytes
	localparam logic [2:0] CALL_BYTES = 3'h2;
	localparam logic [2:0] INT_BYTES = 3'h5;
	// Vector slot numbers, in address order
	localparam logic [2:0] VEC_TIMER_WAIT = 3'h0;
	localparam logic [2:0] VEC_TIMER = 3'h1;
	localparam logic [2:0] VEC_EXTERNAL = 3'h2;
	localparam logic [2:0] VEC_SOFT_TRAP = 3'h3;
	localparam logic [2:0] VEC_POWER_ON = 3'h4;
	// Stack sequencer states
	typedef enum logic [2:0] {
		CSPR_IDLE = 3'b001,
		CSPR_PUSH = 3'b010,
		CSPR_PULL = 3'b100
	} cspr_state_t;
endpackage

// file: rtl/cspr_ram.sv
// Single-port byte RAM for the low part of the address map.
// Assumes one clock; reads are registered and show one cycle later.
`timescale 1ns/10ps
`default_nettype none
module cspr_ram #(
	parameter int DEPTH = 128,
	parameter int AW = 7
) (
	// Clock
	input wire logic clock_i,
	// Access
	input wire logic we_i,
	input wire logic [AW-1:0] addr_i,
	input wire logic [7:0] wdata_i,
	output logic [7:0] rdata_o
);
	logic [7:0] mem [DEPTH];

	// Write, and registered read that returns the contents from before the write
	always_ff @(posedge clock_i) begin
		if (we_i) begin
			mem[addr_i] <= wdata_i;
		end
		rdata_o <= mem[addr_i];
	end
endmodule
`default_nettype wire

// file: rtl/cspr_stack.sv
// Stack pointer, RAM stack and address decode of a small 8-bit CPU.
// Assumes the CPU core issues one request at a time and waits on busy_o.
`timescale 1ns/10ps
`default_nettype none
module cspr_stack #(
	parameter int PC_W = 13,
	parameter int RAM_DEPTH = 128
) (
	// Clock and reset
	input wire logic clock_i,
	input wire logic rst_n_i,
	// Frame requests from the core
	input wire logic call_i,
	input wire logic irq_entry_i,
	input wire logic ret_i,
	input wire logic rti_i,
	input wire logic [PC_W-1:0] ret_addr_i,
	input wire logic [7:0] ccr_i,
	input wire logic [7:0] acc_i,
	input wire logic [7:0] idx_i,
	// Frame results
	output logic busy_o,
	output logic done_o,
	output logic [PC_W-1:0] pulled_pc_o,
	output logic [7:0] pulled_ccr_o,
	output logic [7:0] pulled_acc_o,
	output logic [7:0] pulled_idx_o,
	output logic [PC_W-1:0] sp_o,
	// Plain load and store port
	input wire logic mem_rd_i,
	input wire logic mem_wr_i,
	input wire logic [PC_W-1:0] mem_addr_i,
	input wire logic [7:0] mem_wdata_i,
	output logic [7:0] mem_rdata_o,
	output logic mem_ram_hit_o,
	output logic mem_periph_hit_o,
	// Peripheral register strobes
	output logic periph_wr_o,
	output logic periph_rd_o,
	output logic [PC_W-1:0] periph_addr_o,
	output logic [7:0] periph_wdata_o,
	input wire logic [7:0] periph_rdata_i,
	// Vector lookup
	input wire logic [2:0] vec_sel_i,
	output logic [PC_W-1:0] vec_addr_o
);
	localparam logic [PC_W-1:0] TOP = PC_W'(cspr_pkg::STACK_TOP);
	localparam logic [PC_W-1:0] BASE = PC_W'(cspr_pkg::STACK_BASE);

	cspr_pkg::cspr_state_t state_reg;
	logic [PC_W-1:0] sp_reg;
	logic [2:0] cnt_reg;
	logic [2:0] len_reg;
	logic [7:0] frame_reg [5];
	logic [7:0] pull_reg [5];
	logic pull_valid_reg;
	logic [2:0] pull_idx_reg;
	logic ram_we;
	logic [6:0] ram_addr;
	logic [7:0] ram_wdata;
	logic [7:0] ram_rdata;
	logic rd_pend_reg;
	logic rd_ram_reg;

	// True when an address lands in on-chip RAM
	function automatic logic is_ram(input logic [PC_W-1:0] a);
		return a < PC_W'(cspr_pkg::RAM_LIMIT);
	endfunction

	// True when an address lands in peripheral registers
	function automatic logic is_periph(input logic [PC_W-1:0] a);
		return a < PC_W'(cspr_pkg::PERIPH_LIMIT);
	endfunction

	// Pointer after a push, wrapping at the stack limit
	function automatic logic [PC_W-1:0] sp_dec(input logic [PC_W-1:0] p);
		return (p == BASE) ? TOP : p - PC_W'(1);
	endfunction

	// Pointer after a pull, wrapping at the top
	function automatic logic [PC_W-1:0] sp_inc(input logic [PC_W-1:0] p);
		return (p == TOP) ? BASE : p + PC_W'(1);
	endfunction

	// Stack sequencer
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			state_reg <= cspr_pkg::CSPR_IDLE;
			cnt_reg <= 3'h0;
			len_reg <= 3'h0;
		end else begin
			unique case (state_reg)
				cspr_pkg::CSPR_IDLE: begin
					cnt_reg <= 3'h0;
					if (irq_entry_i) begin
						len_reg <= cspr_pkg::INT_BYTES;
						state_reg <= cspr_pkg::CSPR_PUSH;
					end else if (call_i) begin
						len_reg <= cspr_pkg::CALL_BYTES;
						state_reg <= cspr_pkg::CSPR_PUSH;
					end else if (rti_i) begin
						len_reg <= cspr_pkg::INT_BYTES;
						state_reg <= cspr_pkg::CSPR_PULL;
					end else if (ret_i) begin
						len_reg <= cspr_pkg::CALL_BYTES;
						state_reg <= cspr_pkg::CSPR_PULL;
					end
				end
				cspr_pkg::CSPR_PUSH: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == len_reg - 3'h1) begin
						state_reg <= cspr_pkg::CSPR_IDLE;
					end
				end
				cspr_pkg::CSPR_PULL: begin
					cnt_reg <= cnt_reg + 3'h1;
					if (cnt_reg == len_reg) begin
						state_reg <= cspr_pkg::CSPR_IDLE;
					end
				end
				default: state_reg <= cspr_pkg::CSPR_IDLE;
			endcase
		end
	end

	// Frame capture: low PC byte first so it ends deepest
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			for (int i = 0; i < 5; i++) begin
				frame_reg[i] <= 8'h00;
			end
		end else if (state_reg == cspr_pkg::CSPR_IDLE) begin
			frame_reg[0] <= ret_addr_i[7:0];
			frame_reg[1] <= 8'(ret_addr_i >> 8);
			frame_reg[2] <= idx_i;
			frame_reg[3] <= acc_i;
			frame_reg[4] <= ccr_i;
		end
	end

	// Stack pointer; write at pointer, then move it
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			sp_reg <= TOP;
		end else if (state_reg == cspr_pkg::CSPR_PUSH) begin
			sp_reg <= sp_dec(sp_reg);
		end else if (state_reg == cspr_pkg::CSPR_PULL &&
				cnt_reg < len_reg) begin
			sp_reg <= sp_inc(sp_reg);
		end
	end

	// RAM port steering between stack and plain accesses
	always_comb begin
		ram_we = 1'b0;
		ram_addr = mem_addr_i[6:0];
		ram_wdata = mem_wdata_i;
		if (state_reg == cspr_pkg::CSPR_PUSH) begin
			ram_we = 1'b1;
			ram_addr = sp_reg[6:0];
			ram_wdata = frame_reg[cnt_reg];
		end else if (state_reg == cspr_pkg::CSPR_PULL) begin
			ram_addr = 7'(sp_inc(sp_reg));
		end else begin
			ram_we = mem_wr_i && is_ram(mem_addr_i) &&
				!is_periph(mem_addr_i);
		end
	end

	cspr_ram #(
		.DEPTH(RAM_DEPTH),
		.AW(7)
	) u_ram (
		.clock_i(clock_i),
		.we_i(ram_we),
		.addr_i(ram_addr),
		.wdata_i(ram_wdata),
		.rdata_o(ram_rdata)
	);

	// Pulled bytes land in reverse push order
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			pull_valid_reg <= 1'b0;
			pull_idx_reg <= 3'h0;
			for (int i = 0; i < 5; i++) begin
				pull_reg[i] <= 8'h00;
			end
		end else begin
			pull_valid_reg <= (state_reg == cspr_pkg::CSPR_PULL) &&
				(cnt_reg < len_reg);
			pull_idx_reg <= len_reg - 3'h1 - cnt_reg;
			if (pull_valid_reg) begin
				pull_reg[pull_idx_reg] <= ram_rdata;
			end
		end
	end

	// Frame results and busy flag
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			busy_o <= 1'b0;
			done_o <= 1'b0;
			pulled_pc_o <= '0;
			pulled_ccr_o <= 8'h00;
			pulled_acc_o <= 8'h00;
			pulled_idx_o <= 8'h00;
			sp_o <= TOP;
		end else begin
			busy_o <= (state_reg == cspr_pkg::CSPR_IDLE) ?
				(call_i || irq_entry_i || ret_i || rti_i) :
				!((state_reg == cspr_pkg::CSPR_PUSH &&
				cnt_reg == len_reg - 3'h1) ||
				(state_reg == cspr_pkg::CSPR_PULL &&
				cnt_reg == len_reg));
			done_o <= (state_reg == cspr_pkg::CSPR_PUSH &&
				cnt_reg == len_reg - 3'h1) ||
				(state_reg == cspr_pkg::CSPR_PULL &&
				cnt_reg == len_reg);
			sp_o <= sp_reg;
			if (state_reg == cspr_pkg::CSPR_PULL && cnt_reg == len_reg) begin
				pulled_pc_o <= PC_W'({pull_reg[1], ram_rdata}); // Low byte lands now
				if (len_reg == cspr_pkg::INT_BYTES) begin
					pulled_idx_o <= pull_reg[2];
					pulled_acc_o <= pull_reg[3];
					pulled_ccr_o <= pull_reg[4];
				end
			end
		end
	end

	// Plain load and store decode
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			periph_wr_o <= 1'b0;
			periph_rd_o <= 1'b0;
			periph_addr_o <= '0;
			periph_wdata_o <= 8'h00;
			mem_ram_hit_o <= 1'b0;
			mem_periph_hit_o <= 1'b0;
			rd_pend_reg <= 1'b0;
			rd_ram_reg <= 1'b0;
			mem_rdata_o <= 8'h00;
		end else begin
			periph_wr_o <= mem_wr_i && is_periph(mem_addr_i);
			periph_rd_o <= mem_rd_i && is_periph(mem_addr_i);
			periph_addr_o <= mem_addr_i;
			periph_wdata_o <= mem_wdata_i;
			mem_ram_hit_o <= (mem_rd_i || mem_wr_i) &&
				is_ram(mem_addr_i) && !is_periph(mem_addr_i);
			mem_periph_hit_o <= (mem_rd_i || mem_wr_i) &&
				is_periph(mem_addr_i);
			rd_pend_reg <= mem_rd_i && state_reg == cspr_pkg::CSPR_IDLE;
			rd_ram_reg <= is_ram(mem_addr_i) && !is_periph(mem_addr_i);
			if (rd_pend_reg) begin
				mem_rdata_o <= rd_ram_reg ? ram_rdata : periph_rdata_i;
			end
		end
	end

	// Vector word address, slots in ascending order
	always_ff @(posedge clock_i) begin
		if (!rst_n_i) begin
			vec_addr_o <= PC_W'(cspr_pkg::VEC_RESET);
		end else if (vec_sel_i > cspr_pkg::VEC_POWER_ON) begin
			vec_addr_o <= PC_W'(cspr_pkg::VEC_RESET);
		end else begin
			vec_addr_o <= PC_W'(cspr_pkg::VEC_BASE) +
				PC_W'({vec_sel_i, 1'b0});
		end
	end

	// Checks
	a_width_range: assert property (@(posedge clock_i)
		PC_W >= 11 && PC_W <= cspr_pkg::ADDR_W)
		else $error("pointer width out of range");
	sequence s_push_start;
		state_reg == cspr_pkg::CSPR_IDLE && irq_entry_i;
	endsequence

	a_reset_top: assert property (@(posedge clock_i)
		!rst_n_i |=> sp_reg == TOP)
		else $error("pointer not at top after reset");
	a_int_five: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) s_push_start |=>
		(state_reg == cspr_pkg::CSPR_PUSH)[*5] ##1
		state_reg == cspr_pkg::CSPR_IDLE)
		else $error("interrupt frame not five bytes");
	a_call_two: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) state_reg == cspr_pkg::CSPR_IDLE &&
		call_i && !irq_entry_i |=>
		(state_reg == cspr_pkg::CSPR_PUSH)[*2] ##1
		state_reg == cspr_pkg::CSPR_IDLE)
		else $error("call frame not two bytes");
	a_push_at_sp: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) ram_we &&
		state_reg == cspr_pkg::CSPR_PUSH |->
		ram_addr == sp_reg[6:0] ##1 sp_reg == sp_dec($past(sp_reg)))
		else $error("push not at free location");
	a_sp_wrap: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) state_reg == cspr_pkg::CSPR_PUSH &&
		sp_reg == BASE |=> sp_reg == TOP)
		else $error("pointer did not wrap");
	a_sp_in_stack: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) sp_reg >= BASE && sp_reg <= TOP)
		else $error("pointer left stack area");
	a_ram_window: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) mem_ram_hit_o |->
		$past(mem_addr_i) < PC_W'(cspr_pkg::RAM_LIMIT))
		else $error("RAM hit above 128");
	a_periph_map: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) mem_wr_i && is_periph(mem_addr_i) |=>
		periph_wr_o && !mem_ram_hit_o)
		else $error("peripheral store missed");
	a_vec_reset: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) vec_sel_i == cspr_pkg::VEC_POWER_ON |=>
		vec_addr_o == PC_W'(cspr_pkg::VEC_RESET))
		else $error("reset vector misplaced");
	a_lifo_balance: assert property (@(posedge clock_i)
		disable iff (!rst_n_i) state_reg == cspr_pkg::CSPR_IDLE &&
		!irq_entry_i && !call_i && rti_i |=> ##6
		sp_reg == sp_inc(sp_inc(sp_inc(sp_inc(sp_inc($past(sp_reg, 7)))))))
		else $error("pull did not unwind five");
endmodule
`default_nettype wire

// file: sim/cspr_tb.sv
// Self-checking bench for the stack pointer and RAM stack block.
// Assumes cspr_pkg is compiled first; inputs change at falling edges.
`timescale 1ns/10ps
`default_nettype none
module tb;
	typedef struct {
		logic [12:0] pc;
		logic [7:0] c, a, x;
		logic [12:0] sp;
		int k;
	} cspr_exp_t;
	logic clock_i = '0, rst_n_i = '0, call_i = '0, irq_entry_i = '0;
	logic ret_i = '0, rti_i = '0, mem_rd_i = '0, mem_wr_i = '0, d1 = '0, d2 = '0;
	logic [12:0] ret_addr_i = '0, mem_addr_i = '0, sp_m = 13'h7f;
	logic [12:0] sp_o, pulled_pc_o, vec_addr_o, periph_addr_o;
	logic [7:0] ccr_i = '0, acc_i = '0, idx_i = '0, mem_wdata_i = '0;
	logic [7:0] periph_rdata_i = '0, pulled_ccr_o, pulled_acc_o, pulled_idx_o;
	logic [7:0] mem_rdata_o, periph_wdata_o;
	logic busy_o, done_o, mem_ram_hit_o, mem_periph_hit_o;
	logic periph_wr_o, periph_rd_o;
	logic [2:0] vec_sel_i = '0;
	logic [10:0] mr, rq[$];
	int miscompares = 0, num_checks = 0;
	cspr_exp_t fe, fq[$], st[$];

	cspr_stack #(.PC_W(13), .RAM_DEPTH(128)) dut (.clock_i(clock_i),
		.rst_n_i(rst_n_i), .call_i(call_i), .irq_entry_i(irq_entry_i),
		.ret_i(ret_i), .rti_i(rti_i), .ret_addr_i(ret_addr_i), .ccr_i(ccr_i),
		.acc_i(acc_i), .idx_i(idx_i), .busy_o(busy_o), .done_o(done_o),
		.pulled_pc_o(pulled_pc_o), .pulled_ccr_o(pulled_ccr_o),
		.pulled_acc_o(pulled_acc_o), .pulled_idx_o(pulled_idx_o), .sp_o(sp_o),
		.mem_rd_i(mem_rd_i), .mem_wr_i(mem_wr_i), .mem_addr_i(mem_addr_i),
		.mem_wdata_i(mem_wdata_i), .mem_rdata_o(mem_rdata_o),
		.mem_ram_hit_o(mem_ram_hit_o), .mem_periph_hit_o(mem_periph_hit_o),
		.periph_wr_o(periph_wr_o), .periph_rd_o(periph_rd_o),
		.periph_addr_o(periph_addr_o), .periph_wdata_o(periph_wdata_o),
		.periph_rdata_i(periph_rdata_i), .vec_sel_i(vec_sel_i),
		.vec_addr_o(vec_addr_o));

	// Free-running clock, 10 ns period
	initial begin
		forever #5 clock_i = ~clock_i;
	end

	// Hang guard
	initial begin
		#900000;
		miscompares++;
		stop_test();
	end

	task automatic stop_test();
		if (miscompares == 0 && num_checks > 0)
			$display("All checks passed");
		else
			$display("Checks failed");
		$finish;
	endtask

	task automatic chk(input logic [23:0] got, input logic [23:0] exp,
			input string m);
		num_checks++;
		if (got !== exp) begin
			miscompares++;
			$display("BAD %0t %s got %h exp %h", $time, m, got, exp);
		end
	endtask

	function automatic logic [12:0] dn(input logic [12:0] s);
		return (s == 13'h60) ? 13'h7f : s - 13'h1;
	endfunction

	function automatic logic [12:0] up(input logic [12:0] s);
		return (s == 13'h7f) ? 13'h60 : s + 13'h1;
	endfunction

	// One frame: k 0 call, 1 interrupt, 2 return, 3 interrupt return
	task automatic frame(input int k, input int lat);
		cspr_exp_t e;
		int n;
		if (k < 2) begin
			e = '{13'($urandom), 8'($urandom), 8'($urandom), 8'($urandom), sp_m, k};
			repeat (k ? 5 : 2) sp_m = dn(sp_m);
			st.push_back(e);
		end else begin
			e = st.pop_back();
			repeat (k > 2 ? 5 : 2) sp_m = up(sp_m);
		end
		e.k = k;
		e.sp = sp_m;
		fq.push_back(e);
		@(negedge clock_i);
		ret_addr_i = e.pc;
		{ccr_i, acc_i, idx_i} = {e.c, e.a, e.x};
		{call_i, irq_entry_i, ret_i, rti_i} = 4'h8 >> k;
		@(negedge clock_i);
		{call_i, irq_entry_i, ret_i, rti_i} = '0;
		chk(24'(busy_o), 24'h1, "busy"); // Frame in progress
		n = 1;
		while (done_o !== 1'b1 && n < 50) begin
			@(negedge clock_i);
			n++;
		end
		if (n >= 50) begin
			miscompares++;
			stop_test();
		end else begin
			chk(24'(n), 24'(lat), "latency"); // Byte count sets length
			repeat (2) @(negedge clock_i);
		end
	endtask

	// Plain access; f is {check data, RAM hit, peripheral hit}
	task automatic mem(input logic wr, input logic [12:0] a,
			input logic [7:0] d, input logic [2:0] f);
		@(negedge clock_i);
		mem_addr_i = a;
		mem_wdata_i = d;
		periph_rdata_i = d;
		mem_wr_i = wr;
		mem_rd_i = !wr;
		if (!wr)
			rq.push_back({f, d});
		@(negedge clock_i);
		mem_wr_i = '0;
		mem_rd_i = '0;
		if (wr) begin
			chk(24'(periph_wr_o), 24'(f[0]), "pwr"); // Stores reach registers
			chk(24'(mem_ram_hit_o), 24'(f[1]), "whit"); // RAM decode
			if (f[0])
				chk(24'({periph_addr_o, periph_wdata_o}), 24'({a, d}), "pbus");
		end
		@(negedge clock_i);
	endtask

	// Frame result watcher
	always @(negedge clock_i) begin
		if (done_o === 1'b1) begin
			if (fq.size() == 0) begin
				miscompares++;
				stop_test();
			end else begin
				fe = fq.pop_front();
				chk(24'(busy_o), 24'h0, "busy end"); // Frame ends
				if (fe.k > 1)
					chk(24'(pulled_pc_o), 24'(fe.pc), "pc"); // Last in first out
				if (fe.k == 3)
					chk({pulled_ccr_o, pulled_acc_o, pulled_idx_o},
						{fe.c, fe.a, fe.x}, "st");
				@(negedge clock_i);
				chk(24'(sp_o), 24'(fe.sp), "sp"); // Pointer and wrap
			end
		end
	end

	// Read pipeline tracker
	always @(posedge clock_i) begin
		d1 <= mem_rd_i;
		d2 <= d1;
	end

	// Read result watcher
	always @(negedge clock_i) begin
		if (d2 && rq.size() > 0) begin
			mr = rq.pop_front();
			if (mr[10])
				chk(24'(mem_rdata_o), 24'(mr[7:0]), "rdata"); // RAM holds data
		end
		if (d1 && rq.size() > 0) begin
			mr = rq[0];
			chk(24'({mem_ram_hit_o, mem_periph_hit_o, periph_rd_o}),
				24'({mr[9:8], mr[8]}), "rhit");
		end
	end

	// Main sequence
	initial begin
		logic [12:0] a;
		logic [7:0] d;
		void'($urandom(47602));
		repeat (20) @(negedge clock_i);
		chk({sp_o, 11'(vec_addr_o)}, {13'h7f, 11'h7fe}, "reset");
		rst_n_i = '1;
		frame(0, 3);
		mem(0, 13'h7f, st[0].pc[7:0], 3'h6); // Return address in stack RAM
		frame(2, 4);
		frame(0, 3);
		frame(1, 6);
		frame(0, 3);
		frame(2, 4);
		frame(3, 7);
		frame(2, 4);
		repeat (17) frame(0, 3); // Overrun wraps to top
		repeat (16) frame(2, 4);
		@(negedge clock_i);
		rst_n_i = '0;
		repeat (2) @(negedge clock_i);
		chk(24'(sp_o), 24'h7f, "mid reset");
		rst_n_i = '1;
		sp_m = 13'h7f;
		st.delete();
		frame(1, 6);
		frame(3, 7);
		for (int s = 0; s < 6; s++) begin
			@(negedge clock_i);
			vec_sel_i = 3'(s);
			@(negedge clock_i);
			chk(24'(vec_addr_o), s > 4 ? 24'h1ffe : 24'h1ff6 + 24'(2 * s),
				"vec"); // Vector order
		end
		for (int i = 0; i < 10; i++) begin
			a = (i == 0) ? 13'h10 : (i == 1) ? 13'h7f : 13'h10 + 13'($urandom % 112);
			d = 8'($urandom);
			mem(1, a, d, 3'h2);
			mem(0, a, d, 3'h6); // RAM in low 128
			a = 13'($urandom % 16);
			mem(1, a, d, 3'h1); // Peripheral window
			mem(0, a, d, 3'h5); // Peripheral read data
		end
		mem(1, 13'h80, 8'h5a, 3'h0); // Outside RAM
		mem(0, 13'h1000, 8'h00, 3'h0);
		repeat (4) @(negedge clock_i);
		stop_test();
	end
endmodule
`default_nettype wire
